// ==== inc/fpc_pkg.sv ====
// package: opcodes, condition codes and command structs for the op-class block
package fpc_pkg;
   // ===================================================
   // widths
   localparam int NREG = 8;
   localparam int XW = 96;
   localparam int MW = 80;
   localparam int HW = 32;
   // ===================================================
   // operation classes
   typedef enum logic [1:0] {
      FPC_CLS_MOVEM,
      FPC_CLS_MONADIC,
      FPC_CLS_DYADIC,
      FPC_CLS_COND
   } fpc_cls_t;
   // operand sources
   typedef enum logic [1:0] {
      FPC_SRC_FPREG,
      FPC_SRC_MEM,
      FPC_SRC_HOSTREG
   } fpc_src_t;
   // ===================================================
   // monadic operation codes
   localparam logic [5:0] OP_ABS = 6'h18;
   localparam logic [5:0] OP_ACOS = 6'h1c;
   localparam logic [5:0] OP_ASIN = 6'h0c;
   localparam logic [5:0] OP_ATAN = 6'h0a;
   localparam logic [5:0] OP_ATANH = 6'h0d;
   localparam logic [5:0] OP_COS = 6'h1d;
   localparam logic [5:0] OP_COSH = 6'h19;
   localparam logic [5:0] OP_ETOX = 6'h10;
   localparam logic [5:0] OP_ETOXM1 = 6'h08;
   localparam logic [5:0] OP_GETEXP = 6'h1e;
   localparam logic [5:0] OP_GETMAN = 6'h1f;
   localparam logic [5:0] OP_INT = 6'h01;
   localparam logic [5:0] OP_TRUNC_INT = 6'h03;
   localparam logic [5:0] OP_LOG10 = 6'h15;
   localparam logic [5:0] OP_LOG2 = 6'h16;
   localparam logic [5:0] OP_LOGN = 6'h14;
   localparam logic [5:0] OP_LOG_1PX = 6'h06;
   localparam logic [5:0] OP_NEG = 6'h1a;
   localparam logic [5:0] OP_SIN = 6'h0e;
   localparam logic [5:0] OP_SIN_COS = 6'h30;
   localparam logic [5:0] OP_SINH = 6'h02;
   localparam logic [5:0] OP_SQRT = 6'h04;
   localparam logic [5:0] OP_TAN = 6'h0f;
   localparam logic [5:0] OP_TANH = 6'h09;
   localparam logic [5:0] OP_TENTOX = 6'h12;
   localparam logic [5:0] OP_TEST = 6'h3a;
   localparam logic [5:0] OP_TWOTOX = 6'h11;
   // dyadic operation codes
   localparam logic [5:0] OP_ADD = 6'h22;
   localparam logic [5:0] OP_CMP = 6'h38;
   localparam logic [5:0] OP_DIV = 6'h20;
   localparam logic [5:0] OP_MOD = 6'h21;
   localparam logic [5:0] OP_MUL = 6'h23;
   localparam logic [5:0] OP_REM = 6'h25;
   localparam logic [5:0] OP_SCALE = 6'h26;
   localparam logic [5:0] OP_SGL_DIV = 6'h24;
   localparam logic [5:0] OP_SGL_MUL = 6'h27;
   localparam logic [5:0] OP_SUB = 6'h28;
   // ===================================================
   // condition code bit positions (n z i nan)
   localparam int CC_NAN = 0;
   localparam int CC_I = 1;
   localparam int CC_Z = 2;
   localparam int CC_N = 3;
   // predicate field: bit 4 marks a signaling specifier
   localparam int PRED_SIG = 4;
   localparam logic [7:0] XBYTE_RST = 8'h00;
   localparam int XB_UNORD = 7;
   // ===================================================
   // command from the host side
   typedef struct packed {
      fpc_cls_t cls;
      logic [5:0] op;
      fpc_src_t src;
      logic [2:0] src_reg;
      logic [2:0] dst_reg;
      logic one_reg;
      logic to_mem;
      logic dyn_mask;
      logic [7:0] static_mask;
      logic [4:0] pred;
   } fpc_cmd_t;
   // request to the arithmetic unit
   typedef struct packed {
      logic [5:0] op;
      logic [MW-1:0] opa;
      logic [MW-1:0] opb;
      logic [2:0] dst;
      logic [2:0] dst2;
      logic pair;
   } fpc_alu_req_t;
endpackage

// ==== rtl/fpc_cond_eval.sv ====
// condition evaluator: 32 predicates on the condition code nibble
`timescale 1ns/1ns
module fpc_cond_eval
   import fpc_pkg::*;
(
   // predicate and codes
   input wire logic [4:0] pred_i,
   input wire logic [3:0] cc_i,
   // answer
   output logic true_o,
   output logic unord_o
);
   // ===================================================
   // base terms
   wire n = cc_i[CC_N];
   wire z = cc_i[CC_Z];
   wire u = cc_i[CC_NAN];
   wire [15:0] tbl;
   // ===================================================
   // sixteen predicate values, repeated for signaling half
   assign tbl[0] = 1'b0;
   assign tbl[1] = z;
   assign tbl[2] = ~(u | z | n);
   assign tbl[3] = z | ~(u | n);
   assign tbl[4] = n & ~(u | z);
   assign tbl[5] = z | (n & ~u);
   assign tbl[6] = ~(u | z);
   assign tbl[7] = ~u;
   assign tbl[8] = u;
   assign tbl[9] = u | z;
   assign tbl[10] = u | ~(n | z);
   assign tbl[11] = u | ~n | z;
   assign tbl[12] = u | (n & ~z);
   assign tbl[13] = u | z | n;
   assign tbl[14] = ~z;
   assign tbl[15] = 1'b1;
   assign true_o = tbl[pred_i[3:0]];
   assign unord_o = pred_i[PRED_SIG] & u;
endmodule

// ==== rtl/fpc_op_class.sv ====
// operation-class decoder: move multiple, monadic, dyadic, conditions
`timescale 1ns/1ns
module fpc_op_class
   import fpc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // command from host
   input wire logic cmd_valid_i,
   input wire fpc_cmd_t cmd_i,
   input wire logic [7:0] host_mask_i,
   input wire logic [MW-1:0] host_data_i,
   input wire logic [3:0] cc_i,
   // data register file view
   input wire logic [NREG*MW-1:0] fp_regs_i,
   // memory word stream, host-side
   input wire logic mem_valid_i,
   input wire logic [XW-1:0] mem_data_i,
   // outputs
   output logic busy_o,
   output logic mm_wr_o,
   output logic mm_rd_o,
   output logic [2:0] mm_reg_o,
   output logic [XW-1:0] mm_data_o,
   output logic reg_we_o,
   output logic [2:0] reg_wsel_o,
   output logic [MW-1:0] reg_wdata_o,
   output logic alu_valid_o,
   output fpc_alu_req_t alu_o,
   output logic cond_valid_o,
   output logic cond_true_o,
   output logic [7:0] xbyte_o,
   output logic bad_op_o
);
   // ===================================================
   // state
   typedef enum logic [1:0] {FPC_IDLE, FPC_MOVE} fpc_st_t;
   fpc_st_t st_r, st_nxt;
   logic [7:0] mask_r, mask_nxt;
   logic to_mem_r;
   // ===================================================
   // decoding
   wire is_go = ce_i & cmd_valid_i & (st_r == FPC_IDLE);
   wire [7:0] sel_mask = cmd_i.dyn_mask ? host_mask_i
                                        : cmd_i.static_mask;
   // lowest pending register, one hot to index
   logic [2:0] low_idx;
   logic [7:0] low_bit;
   always_comb begin
      low_idx = 3'h0;
      low_bit = 8'h00;
      for (int i = NREG - 1; i >= 0; i--) begin
         if (mask_r[i]) begin
            low_idx = 3'(i);
            low_bit = 8'h01 << i;
         end
      end
   end
   wire [MW-1:0] fp_low = fp_regs_i[low_idx*MW +: MW];
   wire [MW-1:0] fp_src = fp_regs_i[cmd_i.src_reg*MW +: MW];
   wire [MW-1:0] fp_dst = fp_regs_i[cmd_i.dst_reg*MW +: MW];
   wire [MW-1:0] opa = (cmd_i.src == FPC_SRC_FPREG) ?
                       (cmd_i.one_reg ? fp_dst : fp_src) :
                       (cmd_i.src == FPC_SRC_MEM) ?
                       mem_data_i[MW-1:0] : host_data_i;
   // op-set membership
   logic mon_ok, dya_ok;
   always_comb begin
      unique case (cmd_i.op)
         OP_ABS, OP_ACOS, OP_ASIN, OP_ATAN, OP_ATANH, OP_COS, OP_COSH,
         OP_ETOX, OP_ETOXM1, OP_GETEXP, OP_GETMAN, OP_INT, OP_TRUNC_INT,
         OP_LOG10, OP_LOG2, OP_LOGN, OP_LOG_1PX, OP_NEG, OP_SIN, OP_SIN_COS,
         OP_SINH, OP_SQRT, OP_TAN, OP_TANH, OP_TENTOX, OP_TEST,
         OP_TWOTOX: mon_ok = 1'b1;
         default: mon_ok = 1'b0;
      endcase
      unique case (cmd_i.op)
         OP_ADD, OP_CMP, OP_DIV, OP_MOD, OP_MUL, OP_REM, OP_SCALE,
         OP_SGL_DIV, OP_SGL_MUL, OP_SUB: dya_ok = 1'b1;
         default: dya_ok = 1'b0;
      endcase
   end
   wire src_wait = (cmd_i.src == FPC_SRC_MEM) & ~mem_valid_i;
   wire do_mon = is_go & (cmd_i.cls == FPC_CLS_MONADIC) & ~src_wait;
   wire do_dya = is_go & (cmd_i.cls == FPC_CLS_DYADIC) & ~src_wait;
   wire do_cond = is_go & (cmd_i.cls == FPC_CLS_COND);
   wire do_mm = is_go & (cmd_i.cls == FPC_CLS_MOVEM) & (sel_mask != 8'h00);
   // condition evaluation
   logic c_true, c_unord;
   fpc_cond_eval u_cond (
      .pred_i(cmd_i.pred),
      .cc_i(cc_i),
      .true_o(c_true),
      .unord_o(c_unord)
   );
   // move step
   wire mm_step = ce_i & (st_r == FPC_MOVE) & (to_mem_r | mem_valid_i);
   wire [7:0] mask_left = mask_r & ~low_bit;
   always_comb begin
      st_nxt = st_r;
      mask_nxt = mask_r;
      if (do_mm) begin
         st_nxt = FPC_MOVE;
         mask_nxt = sel_mask;
      end else if (mm_step) begin
         mask_nxt = mask_left;
         if (mask_left == 8'h00) begin
            st_nxt = FPC_IDLE;
         end
      end
   end
   // ===================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= FPC_IDLE;
         mask_r <= 8'h00;
         to_mem_r <= 1'b0;
      end else if (ce_i) begin
         st_r <= st_nxt;
         mask_r <= mask_nxt;
         if (do_mm) begin
            to_mem_r <= cmd_i.to_mem;
         end
      end
   end
   // move-multiple transfer outputs, raw images
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mm_wr_o <= 1'b0;
         mm_rd_o <= 1'b0;
         mm_reg_o <= 3'h0;
         mm_data_o <= '0;
         reg_we_o <= 1'b0;
         reg_wsel_o <= 3'h0;
         reg_wdata_o <= '0;
      end else if (ce_i) begin
         mm_wr_o <= mm_step & to_mem_r;
         mm_rd_o <= mm_step & ~to_mem_r;
         reg_we_o <= mm_step & ~to_mem_r;
         if (mm_step) begin
            mm_reg_o <= low_idx;
            mm_data_o <= {16'h0000, fp_low};
            reg_wsel_o <= low_idx;
            reg_wdata_o <= mem_data_i[MW-1:0];
         end
      end
   end
   // arithmetic dispatch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alu_valid_o <= 1'b0;
         alu_o <= '0;
         bad_op_o <= 1'b0;
      end else if (ce_i) begin
         alu_valid_o <= (do_mon & mon_ok) | (do_dya & dya_ok);
         bad_op_o <= (do_mon & ~mon_ok) | (do_dya & ~dya_ok);
         if (do_mon | do_dya) begin
            alu_o.op <= cmd_i.op;
            alu_o.opa <= opa;
            alu_o.opb <= fp_dst;
            alu_o.dst <= cmd_i.dst_reg;
            alu_o.dst2 <= cmd_i.src_reg;
            alu_o.pair <= do_mon & (cmd_i.op == OP_SIN_COS);
         end
      end
   end
   // condition answer, trap parameter left to host
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cond_valid_o <= 1'b0;
         cond_true_o <= 1'b0;
         xbyte_o <= XBYTE_RST;
         busy_o <= 1'b0;
      end else if (ce_i) begin
         cond_valid_o <= do_cond;
         busy_o <= (st_nxt != FPC_IDLE);
         if (do_cond) begin
            cond_true_o <= c_true;
            xbyte_o[XB_UNORD] <= xbyte_o[XB_UNORD] | c_unord;
         end
      end
   end
   // ===================================================
   // assertions
   unord_sig_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_cond && cmd_i.pred[PRED_SIG] && cc_i[CC_NAN]
      |=> xbyte_o[XB_UNORD])
      else $error("unordered flag not set");
   unord_quiet_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_cond && !cmd_i.pred[PRED_SIG] && !xbyte_o[XB_UNORD]
      |=> !xbyte_o[XB_UNORD])
      else $error("quiet predicate set unordered flag");
   cond_answer_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_cond |=> cond_valid_o && cond_true_o == $past(c_true))
      else $error("condition answer wrong");
   cond_range_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_cond && cmd_i.pred[3:0] == 4'hf |=> cond_true_o)
      else $error("true predicate false");
   mm_no_exc_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r == FPC_MOVE |-> !alu_valid_o && !bad_op_o)
      else $error("move multiple raised arithmetic activity");
   mm_image_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && mm_step && to_mem_r |=> mm_data_o == {16'h0000, $past(fp_low)})
      else $error("move image altered");
   mm_done_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_mm && cmd_i.to_mem |-> ##[1:9] st_r == FPC_IDLE)
      else $error("move multiple did not finish");
   mon_dst_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_mon && cmd_i.one_reg && cmd_i.src == FPC_SRC_FPREG
      |=> alu_o.opa == $past(fp_dst))
      else $error("single register monadic wrong source");
   dya_dst_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && do_dya |=> alu_o.dst == $past(cmd_i.dst_reg))
      else $error("dyadic destination wrong");
   cov_mm_c: cover property (@(posedge clk_i) do_mm && cmd_i.dyn_mask);
   cov_mon_c: cover property (@(posedge clk_i) do_mon && mon_ok);
   cov_dya_c: cover property (@(posedge clk_i) do_dya && dya_ok);
   cov_cond_c: cover property (@(posedge clk_i) do_cond && c_unord);
endmodule

// ==== verif/fpc_host_model.sv ====
// host-side memory word source for operand fetch and register moves
`timescale 1ns/1ns
module fpc_host_model
   import fpc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pacing: high adds random gaps
   input wire logic slow_i,
   // memory word stream
   output logic mem_valid_o,
   output logic [XW-1:0] mem_data_o
);
   logic [31:0] lf_r;
   logic [2:0] gap_r;
   // ==========================
   // one word per valid cycle, then a gap; data scrambles when not valid
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lf_r <= 32'h1357_9bdf;
         gap_r <= 3'h0;
         mem_valid_o <= 1'b0;
         mem_data_o <= '0;
      end else begin
         lf_r <= {lf_r[30:0], lf_r[31] ^ lf_r[21] ^ lf_r[1] ^ lf_r[0]};
         if (mem_valid_o) begin
            mem_valid_o <= 1'b0;
            gap_r <= slow_i ? {1'b0, lf_r[1:0]} : 3'h0;
            mem_data_o <= ~mem_data_o;
         end else if (gap_r != 3'h0) begin
            gap_r <= gap_r - 3'h1;
            mem_data_o <= ~mem_data_o;
         end else begin
            mem_valid_o <= 1'b1;
            mem_data_o <= {lf_r, ~lf_r, lf_r ^ 32'h5a5a_0ff0};
         end
      end
   end
endmodule

// ==== verif/fpc_op_class_tb.sv ====
// self-checking bench for the operation-class decoder
`timescale 1ns/1ns
module fpc_op_class_tb;
   import fpc_pkg::*;
   // ==========================
   // stimulus, outputs and model state
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   fpc_cmd_t cmd_i = '0;
   logic [7:0] host_mask_i = 8'h00;
   logic [MW-1:0] host_data_i = '0;
   logic [3:0] cc_i = 4'h0;
   logic [NREG*MW-1:0] fp_regs_i = '0;
   logic slow = 1'b0;
   logic mem_valid_i, busy_o, mm_wr_o, mm_rd_o, reg_we_o, alu_valid_o;
   logic cond_valid_o, cond_true_o, bad_op_o;
   logic [XW-1:0] mem_data_i, mm_data_o, last_word;
   logic [2:0] mm_reg_o, reg_wsel_o, ix;
   logic [MW-1:0] reg_wdata_o;
   logic [7:0] xbyte_o;
   fpc_alu_req_t alu_o, e, g;
   logic [1:0] k;
   int n_fail = 0;
   int n_compared = 0;
   int n_bad = 0;
   logic flag = 1'b0;
   logic [31:0] seed = 32'd70021;
   logic [98:0] q_out[$];
   logic [2:0] q_in[$];
   fpc_alu_req_t q_alu[$];
   logic [1:0] q_kind[$];
   logic [8:0] q_cond[$];
   logic [7:0] masks[5] = '{8'h00, 8'hff, 8'h81, 8'h5a, 8'h01};
   logic [5:0] ops[37] = '{OP_ABS, OP_ACOS, OP_ASIN, OP_ATAN, OP_ATANH,
      OP_COS, OP_COSH, OP_ETOX, OP_ETOXM1, OP_GETEXP, OP_GETMAN, OP_INT,
      OP_TRUNC_INT, OP_LOG10, OP_LOG2, OP_LOGN, OP_LOG_1PX, OP_NEG, OP_SIN,
      OP_SIN_COS, OP_SINH, OP_SQRT, OP_TAN, OP_TANH, OP_TENTOX, OP_TEST,
      OP_TWOTOX, OP_ADD, OP_CMP, OP_DIV, OP_MOD, OP_MUL, OP_REM, OP_SCALE,
      OP_SGL_DIV, OP_SGL_MUL, OP_SUB};
   always #10 clk_i = ~clk_i;
   fpc_op_class dut (.clk_i, .rst_i, .ce_i(1'b1), .cmd_valid_i, .cmd_i,
      .host_mask_i, .host_data_i, .cc_i, .fp_regs_i, .mem_valid_i,
      .mem_data_i, .busy_o, .mm_wr_o, .mm_rd_o, .mm_reg_o, .mm_data_o,
      .reg_we_o, .reg_wsel_o, .reg_wdata_o, .alu_valid_o, .alu_o,
      .cond_valid_o, .cond_true_o, .xbyte_o, .bad_op_o);
   fpc_host_model host (.clk_i, .rst_i, .slow_i(slow),
      .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));
   // ==========================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic ord(input logic [2:0] p, input logic [3:0] c);
      return (p[0] & c[CC_Z]) | (p[1] & ~(c[CC_NAN] | c[CC_Z] | c[CC_N]))
         | (p[2] & c[CC_N] & ~(c[CC_NAN] | c[CC_Z]));
   endfunction
   task automatic check(input logic [191:0] got, input logic [191:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic issue(input fpc_cmd_t c);
      int i;
      @(negedge clk_i);
      cmd_i = c;
      cmd_valid_i = 1'b1;
      @(negedge clk_i);
      if (c.cls != FPC_CLS_COND && c.cls != FPC_CLS_MOVEM &&
         c.src == FPC_SRC_MEM)
         for (i = 0; i < 20 && !alu_valid_o && !bad_op_o; i++)
            @(negedge clk_i);
      cmd_valid_i = 1'b0;
   endtask
   task automatic rand_inputs();
      int i;
      for (i = 0; i < NREG * MW / 32; i++) fp_regs_i[i*32 +: 32] = rnd();
      host_data_i = MW'({rnd(), rnd(), rnd()});
   endtask
   task automatic arith(input fpc_cls_t cl, input logic [5:0] op);
      fpc_cmd_t c;
      fpc_alu_req_t x;
      rand_inputs();
      c = '0;
      c.cls = cl;
      c.op = op;
      c.src = fpc_src_t'(2'(rnd() % 3));
      c.src_reg = 3'(rnd());
      c.dst_reg = 3'(rnd());
      c.one_reg = cl == FPC_CLS_MONADIC && c.src == FPC_SRC_FPREG &&
         (rnd() & 32'h1) != 0;
      x.op = op;
      x.dst = c.dst_reg;
      x.dst2 = c.src_reg;
      x.pair = op == OP_SIN_COS;
      x.opb = fp_regs_i[c.dst_reg*MW +: MW];
      x.opa = c.src == FPC_SRC_HOSTREG ? host_data_i :
         fp_regs_i[(c.one_reg ? c.dst_reg : c.src_reg)*MW +: MW];
      q_alu.push_back(x);
      q_kind.push_back({c.src == FPC_SRC_MEM, cl == FPC_CLS_DYADIC});
      issue(c);
   endtask
   task automatic bad(input fpc_cls_t cl, input logic [5:0] op);
      fpc_cmd_t c;
      c = '0;
      c.cls = cl;
      c.op = op;
      n_bad++;
      issue(c);
   endtask
   task automatic movem(input logic out, input logic dyn,
      input logic [7:0] m);
      fpc_cmd_t c;
      int i;
      rand_inputs();
      c = '0;
      c.cls = FPC_CLS_MOVEM;
      c.to_mem = out;
      c.dyn_mask = dyn;
      c.static_mask = dyn ? ~m : m;
      host_mask_i = dyn ? m : ~m;
      for (i = 0; i < NREG; i++)
         if (m[i] && out)
            q_out.push_back({3'(i), 16'h0, fp_regs_i[i*MW +: MW]});
         else if (m[i])
            q_in.push_back(3'(i));
      issue(c);
      @(negedge clk_i);
      for (i = 0; i < 60 && busy_o; i++) @(negedge clk_i);
      repeat (2) @(negedge clk_i);
      check(q_out.size() + q_in.size(), 0);
   endtask
   task automatic cond(input logic [4:0] p);
      fpc_cmd_t c;
      c = '0;
      c.cls = FPC_CLS_COND;
      c.pred = p;
      cc_i = 4'(rnd());
      if (cc_i[CC_NAN]) cc_i[CC_Z] = 1'b0;
      flag = flag | (p[PRED_SIG] & cc_i[CC_NAN]);
      q_cond.push_back({p[3] ? ~ord(~p[2:0], cc_i) : ord(p[2:0], cc_i),
         flag, 7'h00});
      issue(c);
   endtask
   // ==========================
   // result monitor
   always @(posedge clk_i) if (mem_valid_i) last_word <= mem_data_i;
   always @(negedge clk_i) begin
      if (!rst_i) begin
         if (mm_wr_o)
            check({mm_reg_o, mm_data_o}, q_out.pop_front());
         if (mm_rd_o || reg_we_o) begin
            ix = q_in.pop_front();
            check({mm_rd_o, reg_we_o, mm_reg_o, reg_wsel_o, reg_wdata_o},
               {2'b11, ix, ix, last_word[MW-1:0]});
         end
         if (cond_valid_o)
            check({cond_true_o, xbyte_o}, q_cond.pop_front());
         if (bad_op_o) begin
            check(n_bad > 0, 1'b1);
            n_bad--;
         end
         if (alu_valid_o) begin
            k = q_kind.pop_front();
            e = q_alu.pop_front();
            g = alu_o;
            if (k[1]) e.opa = last_word[MW-1:0];
            if (!k[0]) g.opb = e.opb;
            if (!e.pair) g.dst2 = e.dst2;
            check(g, e);
         end
      end
   end
   // ==========================
   // main sequence and watchdog
   initial begin
      #400000;
      n_fail++;
      conclude();
   end
   initial begin
      int i;
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      for (i = 0; i < 64; i++) cond(5'(i));
      for (int r = 0; r < 2; r++) begin
         slow = r[0];
         foreach (ops[j])
            arith(j < 27 ? FPC_CLS_MONADIC : FPC_CLS_DYADIC, ops[j]);
         foreach (masks[j])
            for (i = 0; i < 4; i++) movem(i[0], i[1], masks[j]);
      end
      bad(FPC_CLS_MONADIC, 6'h3f);
      bad(FPC_CLS_DYADIC, OP_ABS);
      for (i = 0; i < 32; i++) cond(5'(i));
      repeat (3) @(negedge clk_i);
      check(q_alu.size() + q_cond.size() + n_bad, 0);
      conclude();
   end
endmodule
